// ===== design/rmf_defs.svh
// How it works
// RQ1 - Common packet layout for every framed packet
// RQ2 - Byte slots; UIDs 48, sub-device and checksum 16
// RQ3 - Multi-byte fields go most significant byte first
// RQ4 - Slot 0 carries start code, else ignored
// RQ5 - Slot 1 sub-start code; responder drops mismatches
// RQ6 - Slot 2 length, counts slots before checksum
// RQ7 - Checksum high at slot given by length
// RQ8 - Fixed header slots for UIDs and fields
// RQ9 - Destination is target UID, source is sender
// RQ10 - Controller broadcasts only discovery or set commands
// RQ11 - All-devices broadcast accepted by every responder
// RQ12 - Maker broadcast accepted on manufacturer match
// RQ13 - No reply to non-discovery broadcasts
// RQ14 - Each responder port has distinct device ID
// RQ15 - One primary port binds the others
// RQ16 - UID is 16-bit maker plus 32-bit device
// RQ17 - Reply only when destination matches own UID; code also replies to broadcast discovery requests
// RQ18 - Parameter length 0 to 231, consistent
// RQ19 - Checksum is 16-bit sum, mismatch discarded
`ifndef RMF_DEFS_SVH
`define RMF_DEFS_SVH
`define RMF_SLOT_SC 9'd0
`define RMF_SLOT_SUB 9'd1
`define RMF_SLOT_LEN 9'd2
`define RMF_SLOT_DST 9'd3
`define RMF_SLOT_DST_END 9'd8
`define RMF_SLOT_SRC 9'd9
`define RMF_SLOT_SRC_END 9'd14
`define RMF_SLOT_TN 9'd15
`define RMF_SLOT_PORT 9'd16
`define RMF_SLOT_MC 9'd17
`define RMF_SLOT_SD 9'd18
`define RMF_SLOT_SD_END 9'd19
`define RMF_SLOT_CC 9'd20
`define RMF_SLOT_PID 9'd21
`define RMF_SLOT_PID_END 9'd22
`define RMF_SLOT_PDL 9'd23
`define RMF_SLOT_PD 9'd24
`define RMF_LEN_MIN 8'h18
`define RMF_PDL_MAX 8'hE7
`define RMF_START_CODE 8'hF0
`define RMF_SUB_START 8'h01
`define RMF_BCAST_MFR 16'hFFFF
`define RMF_BCAST_DEV 32'hFFFFFFFF
`define RMF_CC_DISC 8'h10
`define RMF_CC_SET 8'h30
`define RMF_ERR_SUB 0
`define RMF_ERR_LEN 1
`define RMF_ERR_PDL 2
`define RMF_ERR_SUM 3
`endif

// ===== design/rmf_pkg.sv
`include "rmf_defs.svh"
package rmf_pkg;
  // Header fields of one packet, UIDs as maker/device pairs
  typedef struct packed {
    logic [47:0] dst;
    logic [47:0] src;
    logic [7:0] tn;
    logic [7:0] portType;
    logic [7:0] msgCnt;
    logic [15:0] subDev;
    logic [7:0] cc;
    logic [15:0] pid;
    logic [7:0] pdl;
  } rmf_hdr_s;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} rmf_tx_e;

  // Byte carried by header slot i
  function automatic logic [7:0] rmf_hdr_slot(input rmf_hdr_s h, input logic [7:0] len,
    input logic [7:0] sc, input logic [7:0] sub, input logic [8:0] i);
    logic [7:0] r;
    r = 8'h00;
    case (i) inside
      `RMF_SLOT_SC: r = sc; // RQ4
      `RMF_SLOT_SUB: r = sub; // RQ5
      `RMF_SLOT_LEN: r = len; // RQ6
      [`RMF_SLOT_DST:`RMF_SLOT_DST_END]: r = h.dst[8*(`RMF_SLOT_DST_END - i) +: 8]; // RQ3
      [`RMF_SLOT_SRC:`RMF_SLOT_SRC_END]: r = h.src[8*(`RMF_SLOT_SRC_END - i) +: 8]; // RQ8
      `RMF_SLOT_TN: r = h.tn;
      `RMF_SLOT_PORT: r = h.portType;
      `RMF_SLOT_MC: r = h.msgCnt;
      `RMF_SLOT_SD: r = h.subDev[15:8]; // RQ2
      `RMF_SLOT_SD_END: r = h.subDev[7:0];
      `RMF_SLOT_CC: r = h.cc;
      `RMF_SLOT_PID: r = h.pid[15:8];
      `RMF_SLOT_PID_END: r = h.pid[7:0];
      `RMF_SLOT_PDL: r = h.pdl; // RQ1
      default: r = 8'h00;
    endcase
    return r;
  endfunction
endpackage

// ===== design/rmf_link_if.sv
`timescale 1ns/1ps
// Slot streams: request from controller, reply from responder
interface rmf_link_if;
  logic reqValid;
  logic reqStart;
  logic [7:0] reqData;
  logic rspValid;
  logic rspStart;
  logic [7:0] rspData;
  modport ctrlEnd (output reqValid, output reqStart, output reqData,
    input rspValid, input rspStart, input rspData);
  modport respEnd (input reqValid, input reqStart, input reqData,
    output rspValid, output rspStart, output rspData);
endinterface

// ===== design/rmf_rx_parse.sv
`timescale 1ns/1ps
`include "rmf_defs.svh"
module rmf_rx_parse #(
  parameter logic [7:0] START_CODE = `RMF_START_CODE,
  parameter logic [7:0] SUB_START = `RMF_SUB_START
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic slotValid,
  input wire logic slotStart,
  input wire logic [7:0] slotData,
  output logic done,
  output logic good,
  output logic [3:0] errs,
  output rmf_pkg::rmf_hdr_s hdr,
  output logic pdValid,
  output logic [7:0] pdByte
);
  import rmf_pkg::*;
  logic act_q;
  logic [8:0] idx_q;
  logic [7:0] len_q;
  logic [15:0] sum_q;
  logic [7:0] chkHi_q;
  logic [8:0] lenW;
  logic sumBad;
  assign lenW = {1'b0, len_q};
  assign sumBad = {chkHi_q, slotData} != sum_q;

  // Slot counter and running sum
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      act_q <= 1'b0;
      idx_q <= 9'h000;
      len_q <= 8'h00;
      sum_q <= 16'h0000;
      chkHi_q <= 8'h00;
    end
    else if (ce && slotValid)
    begin
      if (slotStart)
      begin
        act_q <= slotData == START_CODE; // RQ4
        idx_q <= 9'h001;
        sum_q <= {8'h00, slotData};
      end
      else if (act_q)
      begin
        idx_q <= idx_q + 9'h001;
        if (idx_q == `RMF_SLOT_LEN)
          len_q <= slotData; // RQ6
        if (idx_q <= `RMF_SLOT_LEN || idx_q < lenW)
          sum_q <= sum_q + {8'h00, slotData}; // RQ19
        if (idx_q > `RMF_SLOT_LEN && idx_q == lenW)
          chkHi_q <= slotData; // RQ7
        if (idx_q > `RMF_SLOT_LEN && idx_q == lenW + 9'h001)
          act_q <= 1'b0;
      end
    end
  end

  // Header capture, big-endian shift-in
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      hdr <= '0;
    else if (ce && slotValid && !slotStart && act_q && idx_q < `RMF_SLOT_PD)
    begin
      case (idx_q) inside
        [`RMF_SLOT_DST:`RMF_SLOT_DST_END]: hdr.dst <= {hdr.dst[39:0], slotData}; // RQ3
        [`RMF_SLOT_SRC:`RMF_SLOT_SRC_END]: hdr.src <= {hdr.src[39:0], slotData}; // RQ8
        `RMF_SLOT_TN: hdr.tn <= slotData;
        `RMF_SLOT_PORT: hdr.portType <= slotData;
        `RMF_SLOT_MC: hdr.msgCnt <= slotData;
        [`RMF_SLOT_SD:`RMF_SLOT_SD_END]: hdr.subDev <= {hdr.subDev[7:0], slotData}; // RQ2
        `RMF_SLOT_CC: hdr.cc <= slotData;
        [`RMF_SLOT_PID:`RMF_SLOT_PID_END]: hdr.pid <= {hdr.pid[7:0], slotData};
        `RMF_SLOT_PDL: hdr.pdl <= slotData;
        default: hdr.tn <= hdr.tn;
      endcase
    end
  end

  // Checks, parameter data stream and end-of-packet verdict
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      errs <= 4'h0;
      done <= 1'b0;
      good <= 1'b0;
      pdValid <= 1'b0;
      pdByte <= 8'h00;
    end
    else if (ce)
    begin
      done <= 1'b0;
      pdValid <= 1'b0;
      if (slotValid && slotStart)
      begin
        errs <= 4'h0;
        good <= 1'b0;
      end
      else if (slotValid && act_q)
      begin
        if (idx_q == `RMF_SLOT_SUB)
          errs[`RMF_ERR_SUB] <= slotData != SUB_START; // RQ5
        if (idx_q == `RMF_SLOT_LEN)
          errs[`RMF_ERR_LEN] <= slotData < `RMF_LEN_MIN; // RQ6
        if (idx_q == `RMF_SLOT_PDL)
          errs[`RMF_ERR_PDL] <= slotData > `RMF_PDL_MAX ||
            slotData != len_q - 8'(`RMF_SLOT_PD); // RQ18
        if (idx_q >= `RMF_SLOT_PD && idx_q < lenW)
        begin
          pdValid <= 1'b1;
          pdByte <= slotData;
        end
        if (idx_q > `RMF_SLOT_LEN && idx_q == lenW + 9'h001)
        begin
          errs[`RMF_ERR_SUM] <= sumBad; // RQ19
          done <= 1'b1;
          good <= !sumBad && errs[2:0] == 3'b000;
        end
      end
    end
  end
endmodule

// ===== design/rmf_ctrl_end.sv
`timescale 1ns/1ps
`include "rmf_defs.svh"
module rmf_ctrl_end #(
  parameter logic [7:0] START_CODE = `RMF_START_CODE,
  parameter logic [7:0] SUB_START = `RMF_SUB_START,
  parameter logic [31:0] BCAST_DEV = `RMF_BCAST_DEV,
  parameter logic [7:0] CC_DISC = `RMF_CC_DISC,
  parameter logic [7:0] CC_SET = `RMF_CC_SET
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  rmf_link_if.ctrlEnd link,
  input wire logic sendGo,
  input rmf_pkg::rmf_hdr_s sendHdr,
  input wire logic [7:0] pdByte,
  output logic sendBusy,
  output logic sendRefused,
  output logic pdTake,
  output logic [7:0] pdIdx,
  output logic rspDone,
  output logic rspGood,
  output logic [3:0] rspErrs,
  output rmf_pkg::rmf_hdr_s rspHdr,
  output logic rspPdValid,
  output logic [7:0] rspPdByte
);
  import rmf_pkg::*;
  rmf_tx_e st_q;
  rmf_hdr_s hdr_q;
  logic [8:0] idx_q;
  logic [15:0] sum_q;
  logic txValid_q;
  logic txStart_q;
  logic [7:0] txData_q;
  logic [8:0] lenW;
  logic [7:0] b;
  logic refuse;
  assign lenW = `RMF_SLOT_PD + {1'b0, hdr_q.pdl};
  // Broadcast only for discovery or set commands
  assign refuse = sendHdr.dst[31:0] == BCAST_DEV && sendHdr.cc != CC_DISC &&
    sendHdr.cc != CC_SET; // RQ10
  assign sendBusy = st_q == TX_SEND;
  assign link.reqValid = txValid_q;
  assign link.reqStart = txStart_q;
  assign link.reqData = txData_q;

  // Byte for the current slot
  always_comb
  begin
    if (idx_q < `RMF_SLOT_PD)
      b = rmf_hdr_slot(hdr_q, lenW[7:0], START_CODE, SUB_START, idx_q); // RQ1
    else if (idx_q < lenW)
      b = pdByte;
    else if (idx_q == lenW)
      b = sum_q[15:8]; // RQ7
    else
      b = sum_q[7:0];
  end

  // Request serialiser
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= TX_IDLE;
      hdr_q <= '0;
      idx_q <= 9'h000;
      sum_q <= 16'h0000;
      txValid_q <= 1'b0;
      txStart_q <= 1'b0;
      txData_q <= 8'h00;
      sendRefused <= 1'b0;
      pdTake <= 1'b0;
      pdIdx <= 8'h00;
    end
    else if (ce)
    begin
      sendRefused <= 1'b0;
      txValid_q <= 1'b0;
      txStart_q <= 1'b0;
      unique case (st_q)
        TX_IDLE:
        begin
          if (sendGo && refuse)
            sendRefused <= 1'b1; // RQ10
          else if (sendGo)
          begin
            st_q <= TX_SEND;
            hdr_q <= sendHdr; // RQ9
            idx_q <= 9'h000;
            sum_q <= 16'h0000;
            pdIdx <= 8'h00;
          end
        end
        TX_SEND:
        begin
          txValid_q <= 1'b1;
          txStart_q <= idx_q == `RMF_SLOT_SC;
          txData_q <= b;
          idx_q <= idx_q + 9'h001;
          if (idx_q < lenW)
            sum_q <= sum_q + {8'h00, b}; // RQ19
          if (idx_q >= `RMF_SLOT_PD && idx_q < lenW)
            pdIdx <= pdIdx + 8'h01;
          pdTake <= idx_q + 9'h001 >= `RMF_SLOT_PD && idx_q + 9'h001 < lenW;
          if (idx_q == lenW + 9'h001)
            st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Reply receiver
  rmf_rx_parse #(.START_CODE(START_CODE), .SUB_START(SUB_START)) rxParse (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .slotValid(link.rspValid),
    .slotStart(link.rspStart),
    .slotData(link.rspData),
    .done(rspDone),
    .good(rspGood),
    .errs(rspErrs),
    .hdr(rspHdr),
    .pdValid(rspPdValid),
    .pdByte(rspPdByte)
  );
endmodule

// ===== design/rmf_resp_end.sv
`timescale 1ns/1ps
`include "rmf_defs.svh"
module rmf_resp_end #(
  parameter logic [7:0] START_CODE = `RMF_START_CODE,
  parameter logic [7:0] SUB_START = `RMF_SUB_START,
  parameter logic [15:0] BCAST_MFR = `RMF_BCAST_MFR,
  parameter logic [31:0] BCAST_DEV = `RMF_BCAST_DEV,
  parameter logic [7:0] CC_DISC = `RMF_CC_DISC,
  parameter logic [7:0] PORT_NUM = 8'h00
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  rmf_link_if.respEnd link,
  input wire logic [15:0] mfrId,
  input wire logic [31:0] devBase,
  input wire logic rspGo,
  input rmf_pkg::rmf_hdr_s rspHdrIn,
  input wire logic [7:0] pdByte,
  output logic [47:0] ownUid,
  output logic [47:0] primaryUid,
  output logic isPrimary,
  output logic reqDone,
  output logic [3:0] reqErrs,
  output logic reqDropped,
  output logic reqBcast,
  output rmf_pkg::rmf_hdr_s reqHdr,
  output logic reqPdValid,
  output logic [7:0] reqPdByte,
  output logic replyOk,
  output logic rspBusy,
  output logic rspRefused,
  output logic pdTake,
  output logic [7:0] pdIdx
);
  import rmf_pkg::*;
  logic pDone;
  logic pGood;
  logic [3:0] pErrs;
  rmf_hdr_s pHdr;
  logic pPdValid;
  logic [7:0] pPdByte;
  logic toMe;
  logic isAll;
  logic isMaker;
  logic isBcast;
  logic isDisc;
  rmf_tx_e st_q;
  rmf_hdr_s hdr_q;
  logic [8:0] idx_q;
  logic [15:0] sum_q;
  logic txValid_q;
  logic txStart_q;
  logic [7:0] txData_q;
  logic [8:0] lenW;
  logic [7:0] b;

  // Request receiver
  rmf_rx_parse #(.START_CODE(START_CODE), .SUB_START(SUB_START)) rxParse (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .slotValid(link.reqValid),
    .slotStart(link.reqStart),
    .slotData(link.reqData),
    .done(pDone),
    .good(pGood),
    .errs(pErrs),
    .hdr(pHdr),
    .pdValid(pPdValid),
    .pdByte(pPdByte)
  );

  // Identity of this port: maker in the top 16 bits, device below
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ownUid <= 48'h000000000000;
      primaryUid <= 48'h000000000000;
      isPrimary <= 1'b0;
    end
    else if (ce)
    begin
      ownUid <= {mfrId, devBase + {24'h000000, PORT_NUM}}; // RQ14
      primaryUid <= {mfrId, devBase}; // RQ15
      isPrimary <= PORT_NUM == 8'h00; // RQ15
    end
  end

  // Destination decode
  assign toMe = pHdr.dst == ownUid; // RQ17
  assign isAll = pHdr.dst == {BCAST_MFR, BCAST_DEV}; // RQ11
  assign isMaker = pHdr.dst == {ownUid[47:32], BCAST_DEV}; // RQ12
  assign isBcast = !toMe && (isAll || isMaker); // RQ16
  assign isDisc = pHdr.cc == CC_DISC;

  // Request results towards the user
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqDone <= 1'b0;
      reqErrs <= 4'h0;
      reqDropped <= 1'b0;
      reqBcast <= 1'b0;
      reqHdr <= '0;
      reqPdValid <= 1'b0;
      reqPdByte <= 8'h00;
    end
    else if (ce)
    begin
      reqDone <= 1'b0;
      reqDropped <= 1'b0;
      reqPdValid <= pPdValid && (toMe || isAll || isMaker);
      reqPdByte <= pPdByte;
      if (pDone)
      begin
        reqErrs <= pErrs;
        if (pGood && (toMe || isAll || isMaker)) // RQ5
        begin
          reqDone <= 1'b1;
          reqHdr <= pHdr;
          reqBcast <= isBcast; // RQ13
        end
        else
          reqDropped <= 1'b1; // RQ19
      end
    end
  end

  // Reply permission: addressed request, or broadcast discovery request
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      replyOk <= 1'b0;
    else if (ce)
    begin
      if (link.reqValid && link.reqStart)
        replyOk <= 1'b0;
      else if (pDone && pGood && (toMe || ((isAll || isMaker) && isDisc)))
        replyOk <= 1'b1; // RQ13
      else if (st_q == TX_IDLE && rspGo)
        replyOk <= 1'b0;
    end
  end

  assign lenW = `RMF_SLOT_PD + {1'b0, hdr_q.pdl};
  assign rspBusy = st_q == TX_SEND;
  assign link.rspValid = txValid_q;
  assign link.rspStart = txStart_q;
  assign link.rspData = txData_q;

  // Byte for the current reply slot
  always_comb
  begin
    if (idx_q < `RMF_SLOT_PD)
      b = rmf_hdr_slot(hdr_q, lenW[7:0], START_CODE, SUB_START, idx_q); // RQ1
    else if (idx_q < lenW)
      b = pdByte;
    else if (idx_q == lenW)
      b = sum_q[15:8]; // RQ7
    else
      b = sum_q[7:0];
  end

  // Reply serialiser
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= TX_IDLE;
      hdr_q <= '0;
      idx_q <= 9'h000;
      sum_q <= 16'h0000;
      txValid_q <= 1'b0;
      txStart_q <= 1'b0;
      txData_q <= 8'h00;
      rspRefused <= 1'b0;
      pdTake <= 1'b0;
      pdIdx <= 8'h00;
    end
    else if (ce)
    begin
      rspRefused <= 1'b0;
      txValid_q <= 1'b0;
      txStart_q <= 1'b0;
      unique case (st_q)
        TX_IDLE:
        begin
          if (rspGo && !replyOk)
            rspRefused <= 1'b1; // RQ13
          else if (rspGo)
          begin
            st_q <= TX_SEND;
            hdr_q <= rspHdrIn;
            hdr_q.dst <= reqHdr.src; // RQ9
            hdr_q.src <= ownUid; // RQ9
            hdr_q.tn <= reqHdr.tn;
            idx_q <= 9'h000;
            sum_q <= 16'h0000;
            pdIdx <= 8'h00;
          end
        end
        TX_SEND:
        begin
          txValid_q <= 1'b1;
          txStart_q <= idx_q == `RMF_SLOT_SC; // RQ4
          txData_q <= b;
          idx_q <= idx_q + 9'h001;
          if (idx_q < lenW)
            sum_q <= sum_q + {8'h00, b}; // RQ19
          if (idx_q >= `RMF_SLOT_PD && idx_q < lenW)
            pdIdx <= pdIdx + 8'h01;
          pdTake <= idx_q + 9'h001 >= `RMF_SLOT_PD && idx_q + 9'h001 < lenW;
          if (idx_q == lenW + 9'h001)
            st_q <= TX_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== verification/rmf_sva.sv
`timescale 1ns/1ps
`include "rmf_defs.svh"
module rmf_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire logic reqStart,
  input wire logic [7:0] reqData,
  input wire logic rspValid,
  input wire logic rspStart,
  input wire logic [7:0] rspData
);
  logic [8:0] reqCnt_q, rspCnt_q;
  logic [7:0] reqLen_q, rspLen_q, reqCc_q;
  logic [15:0] reqSum_q, rspSum_q;
  logic [47:0] reqDst_q, reqSrc_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Request slot index and running sum
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqCnt_q <= 9'h000;
      reqSum_q <= 16'h0000;
    end
    else if (reqValid)
    begin
      reqCnt_q <= reqStart ? 9'h001 : reqCnt_q + 9'h001;
      if (reqStart)
        reqSum_q <= {8'h00, reqData};
      else if (reqCnt_q < 9'h003 || reqCnt_q < {1'b0, reqLen_q})
        reqSum_q <= reqSum_q + {8'h00, reqData};
    end
  end
  // Request header fields for later checks
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reqLen_q <= 8'h00;
      reqCc_q <= 8'h00;
      reqDst_q <= 48'h0;
      reqSrc_q <= 48'h0;
    end
    else if (reqValid && !reqStart)
    begin
      if (reqCnt_q == 9'h002)
        reqLen_q <= reqData;
      if (reqCnt_q >= 9'h003 && reqCnt_q <= 9'h008)
        reqDst_q <= {reqDst_q[39:0], reqData};
      if (reqCnt_q >= 9'h009 && reqCnt_q <= 9'h00E)
        reqSrc_q <= {reqSrc_q[39:0], reqData};
      if (reqCnt_q == 9'h014)
        reqCc_q <= reqData;
    end
  end
  // Reply slot index, length and running sum
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rspCnt_q <= 9'h000;
      rspSum_q <= 16'h0000;
      rspLen_q <= 8'h00;
    end
    else if (rspValid)
    begin
      rspCnt_q <= rspStart ? 9'h001 : rspCnt_q + 9'h001;
      if (!rspStart && rspCnt_q == 9'h002)
        rspLen_q <= rspData;
      if (rspStart)
        rspSum_q <= {8'h00, rspData};
      else if (rspCnt_q < 9'h003 || rspCnt_q < {1'b0, rspLen_q})
        rspSum_q <= rspSum_q + {8'h00, rspData};
    end
  end
  req_start_code_a: assert property (reqValid && reqStart |-> reqData == `RMF_START_CODE)
    else $error("request slot 0 is not the start code");
  req_sub_start_a: assert property (reqValid && reqStart |=> reqValid && !reqStart
    && reqData == `RMF_SUB_START)
    else $error("request slot 1 is not the sub-start code");
  req_len_range_a: assert property (reqValid && !reqStart && reqCnt_q == 9'h002
    |-> reqData >= `RMF_LEN_MIN)
    else $error("request length below minimum");
  req_gapless_a: assert property (reqValid && !reqStart && reqCnt_q > 9'h002
    && reqCnt_q < {1'b0, reqLen_q} |=> reqValid && !reqStart)
    else $error("request slots not contiguous");
  req_checksum_a: assert property (reqValid && !reqStart && reqCnt_q > 9'h002
    && reqCnt_q == {1'b0, reqLen_q} |-> reqData == reqSum_q[15:8]
    ##1 (reqValid && reqData == reqSum_q[7:0]) ##1 !reqValid)
    else $error("request checksum wrong or misplaced");
  rsp_frame_a: assert property (rspValid && rspStart |-> rspData == `RMF_START_CODE
    ##1 (rspValid && rspData == `RMF_SUB_START))
    else $error("reply start codes wrong");
  rsp_checksum_a: assert property (rspValid && !rspStart && rspCnt_q > 9'h002
    && rspCnt_q == {1'b0, rspLen_q} |-> rspData == rspSum_q[15:8]
    ##1 (rspValid && rspData == rspSum_q[7:0]))
    else $error("reply checksum wrong or misplaced");
  reply_dst_a: assert property (rspValid && !rspStart && rspCnt_q >= 9'h003
    && rspCnt_q <= 9'h008 |-> rspData == reqSrc_q[(9'h008 - rspCnt_q) * 8 +: 8])
    else $error("reply destination is not the request source");
  bcast_quiet_a: assert property (rspValid && rspStart
    |-> !(reqDst_q[31:0] == `RMF_BCAST_DEV && reqCc_q != `RMF_CC_DISC))
    else $error("reply sent to a non-discovery broadcast");
  cover property (reqValid && reqStart);
  cover property (rspValid && rspStart);
  cover property (reqValid && reqCnt_q == 9'h015 && reqDst_q[31:0] == `RMF_BCAST_DEV);
endmodule

// ===== verification/remote_mgmt_packet_framer_tb.sv
`timescale 1ns/1ps
`include "rmf_defs.svh"
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module remote_mgmt_packet_framer_tb;
  import rmf_pkg::*;
  localparam logic [15:0] MFR = 16'h1234; // Arbitrary maker code
  localparam logic [31:0] DEVB = 32'h00000100;
  localparam logic [47:0] CUID = 48'h0ABC00000007;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic sendGo = 1'b0;
  logic rspGo = 1'b0;
  logic clr = 1'b0;
  rmf_hdr_s sendHdr = '0;
  rmf_hdr_s rspHdrIn = '0;
  rmf_hdr_s rspHdr, reqHdr;
  logic sendRefused, rspRefused, rspDone, rspGood, reqDone, reqDropped, reqBcast, replyOk;
  logic rspPdValid, reqPdValid, isPrimary, isPri2, done2, drop2;
  logic [7:0] ctrlIdx, respIdx, rspPdByte, reqPdByte, nPd, lastPd, nRPd, lastRPd;
  logic [7:0] seen;
  logic [3:0] errs2;
  logic [47:0] ownUid, own2, prim2;
  int n_mismatch = 0;
  int num_checks = 0;
  rmf_link_if link();
  rmf_link_if link2();
  rmf_ctrl_end i_rmf_ctrl_end (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .link(link),
    .sendGo(sendGo), .sendHdr(sendHdr), .pdByte(8'hA0 + ctrlIdx), .sendBusy(),
    .sendRefused(sendRefused), .pdTake(), .pdIdx(ctrlIdx), .rspDone(rspDone),
    .rspGood(rspGood), .rspErrs(), .rspHdr(rspHdr), .rspPdValid(rspPdValid),
    .rspPdByte(rspPdByte));
  rmf_resp_end i_rmf_resp_end (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .link(link),
    .mfrId(MFR), .devBase(DEVB), .rspGo(rspGo), .rspHdrIn(rspHdrIn), .pdByte(8'hC0 + respIdx),
    .ownUid(ownUid), .primaryUid(), .isPrimary(isPrimary), .reqDone(reqDone), .reqErrs(),
    .reqDropped(reqDropped), .reqBcast(reqBcast), .reqHdr(reqHdr), .reqPdValid(reqPdValid),
    .reqPdByte(reqPdByte), .replyOk(replyOk), .rspBusy(), .rspRefused(rspRefused),
    .pdTake(), .pdIdx(respIdx));
  rmf_resp_end #(.PORT_NUM(8'h01)) i_rmf_resp_end2 (.sys_clk(sys_clk), .arst_n(arst_n),
    .ce(ce), .link(link2), .mfrId(MFR), .devBase(DEVB), .rspGo(1'b0), .rspHdrIn(rspHdrIn),
    .pdByte(8'h00), .ownUid(own2), .primaryUid(prim2), .isPrimary(isPri2), .reqDone(done2),
    .reqErrs(errs2), .reqDropped(drop2), .reqBcast(), .reqHdr(), .reqPdValid(),
    .reqPdByte(), .replyOk(), .rspBusy(), .rspRefused(), .pdTake(), .pdIdx());
  rmf_sva i_rmf_sva (.sys_clk(sys_clk), .arst_n(arst_n), .reqValid(link.reqValid),
    .reqStart(link.reqStart), .reqData(link.reqData), .rspValid(link.rspValid),
    .rspStart(link.rspStart), .rspData(link.rspData));
  // Clock of 5 ns
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Sticky event flags and byte counts
  always @(posedge sys_clk)
  begin
    seen <= clr ? 8'h00 : seen | {drop2, done2, link.reqValid, rspDone, rspRefused,
      reqDropped, reqDone, sendRefused};
    nPd <= clr ? 8'h00 : nPd + {7'h00, reqPdValid};
    nRPd <= clr ? 8'h00 : nRPd + {7'h00, rspPdValid};
    if (reqPdValid)
      lastPd <= reqPdByte;
    if (rspPdValid)
      lastRPd <= rspPdByte;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic send(input logic [47:0] dst, input logic [7:0] cc);
    sendHdr <= '{dst: dst, src: CUID, tn: 8'h05, portType: 8'h01, msgCnt: 8'h00,
      subDev: 16'h0000, cc: cc, pid: 16'h00F0, pdl: 8'h02};
    clr <= 1'b1;
    sendGo <= 1'b1;
    tick(1);
    clr <= 1'b0;
    sendGo <= 1'b0;
    tick(60);
  endtask
  task automatic reply();
    clr <= 1'b1;
    rspGo <= 1'b1;
    tick(1);
    clr <= 1'b0;
    rspGo <= 1'b0;
    tick(60);
  endtask
  // Raw request on the second link, faults set by caller
  task automatic raw(input logic [7:0] sc, input logic [7:0] sub, input logic [7:0] pdlF,
    input int nPdB, input logic [15:0] adj);
    logic [7:0] b [$];
    logic [15:0] sum;
    logic [47:0] dst;
    dst = {MFR, DEVB + 32'h1};
    b = '{sc, sub, 8'(24 + nPdB)};
    for (int i = 5; i >= 0; i--) b.push_back(dst[8*i +: 8]);
    for (int i = 5; i >= 0; i--) b.push_back(CUID[8*i +: 8]);
    b = {b, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'hF0, pdlF};
    for (int i = 0; i < nPdB; i++) b.push_back(8'hB0 + 8'(i));
    sum = 16'h0000;
    foreach (b[i]) sum = sum + {8'h00, b[i]};
    sum = sum + adj;
    b = {b, sum[15:8], sum[7:0]};
    foreach (b[i])
    begin
      clr <= (i == 0);
      link2.reqValid <= 1'b1;
      link2.reqStart <= (i == 0);
      link2.reqData <= b[i];
      tick(1);
    end
    clr <= 1'b0;
    link2.reqValid <= 1'b0;
    link2.reqStart <= 1'b0;
    link2.reqData <= ~sum[7:0];
    tick(10);
  endtask
  task automatic t_ports();
    `CHK(ownUid, {MFR, DEVB}, "own uid");
    `CHK(own2, {MFR, DEVB + 32'h1}, "second port uid");
    `CHK(prim2, {MFR, DEVB}, "primary uid");
    `CHK({isPrimary, isPri2}, 2'b10, "primary flags");
    $display("t_ports done");
  endtask
  task automatic t_unicast();
    send({MFR, DEVB}, 8'h20);
    `CHK({seen[1], reqBcast, replyOk}, 3'b101, "unicast accept");
    `CHK({reqHdr.dst, reqHdr.src}, {MFR, DEVB, CUID}, "request uids");
    `CHK({reqHdr.tn, reqHdr.cc, reqHdr.pid, reqHdr.pdl}, 40'h052000F002, "mdb");
    `CHK({nPd, lastPd}, 16'h02A1, "request data");
    reply();
    `CHK({seen[4], rspGood}, 2'b11, "reply good");
    `CHK({rspHdr.dst, rspHdr.src}, {CUID, MFR, DEVB}, "reply uids");
    `CHK(rspHdr.tn, 8'h05, "reply tn");
    `CHK({nRPd, lastRPd}, 16'h02C1, "reply data");
    $display("t_unicast done");
  endtask
  task automatic t_bcast();
    logic [47:0] dsts [4] = '{48'hFFFFFFFFFFFF, {MFR, 32'hFFFFFFFF}, {MFR, 32'hFFFFFFFF},
      48'h4321FFFFFFFF};
    logic [7:0] ccs [4] = '{8'h30, 8'h30, 8'h10, 8'h30};
    logic [2:0] exps [4] = '{3'b101, 3'b101, 3'b110, 3'b001};
    for (int i = 0; i < 4; i++)
    begin
      send(dsts[i], ccs[i]);
      `CHK(seen[1], exps[i][2], "broadcast accept");
      `CHK(replyOk, exps[i][1], "broadcast reply permission");
      if (exps[i][2])
        `CHK(reqBcast, 1'b1, "broadcast flag");
      reply();
      `CHK(seen[3], exps[i][0], "broadcast reply refusal");
    end
    $display("t_bcast done");
  endtask
  task automatic t_refuse();
    ce <= 1'b0;
    send('1, 8'h20);
    ce <= 1'b1;
    `CHK(seen[5:0], 6'h00, "ce low");
    send(48'hFFFFFFFFFFFF, 8'h20);
    `CHK({seen[0], seen[5]}, 2'b10, "get broadcast refused");
    send({MFR, DEVB + 32'h2}, 8'h20);
    `CHK({seen[2], seen[1]}, 2'b10, "foreign uid dropped");
    $display("t_refuse done");
  endtask
  task automatic t_faults();
    raw(8'hF0, 8'h01, 8'h02, 2, 16'h0000);
    `CHK({seen[7:6], errs2}, 6'b010000, "good raw packet");
    raw(8'hF0, 8'h02, 8'h02, 2, 16'h0000);
    `CHK({seen[7:6], errs2}, 6'b100001, "bad sub-start");
    raw(8'hF0, 8'h01, 8'h02, 2, 16'h0001);
    `CHK({seen[7:6], errs2}, 6'b101000, "bad checksum");
    raw(8'hF0, 8'h01, 8'h03, 2, 16'h0000);
    `CHK({seen[7:6], errs2}, 6'b100100, "bad data length");
    raw(8'h55, 8'h01, 8'h02, 2, 16'h0000);
    `CHK(seen[7:6], 2'b00, "foreign start code");
    $display("t_faults done");
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog, well past the expected run
  initial
  begin
    #40000;
    n_mismatch++;
    $display("Watchdog expired");
    complete_run();
  end
  initial
  begin
    link2.reqValid = 1'b0;
    link2.reqStart = 1'b0;
    link2.reqData = 8'h00;
    rspHdrIn = '{dst: 48'h0, src: 48'h0, tn: 8'h00, portType: 8'h00, msgCnt: 8'h00,
      subDev: 16'h0000, cc: 8'h21, pid: 16'h00F0, pdl: 8'h02};
    tick(5);
    arst_n <= 1'b1;
    tick(2);
    t_ports();
    t_unicast();
    t_bcast();
    t_refuse();
    t_faults();
    complete_run();
  end
endmodule
